// ==== accumulator_transfer_ops.sv ====
// decode and execute of the accumulator transfer instructions
`timescale 1ns/1ps
module accumulator_transfer_ops
    import accumulator_transfer_pkg::*;
(
    // clock and reset
    input  wire logic                                 clock,
    input  wire logic                                 rst,
    // instruction issue from fetch
    input  wire logic                                 instr_valid,
    input  wire logic [INSTR_WIDTH-1:0]               instr,
    // operands from the core register file
    input  wire logic [ACC_WIDTH-1:0]                 acc,
    input  wire logic [ACC_WIDTH-1:0]                 b_reg,
    // destination registers
    output logic      [D_WIDTH-1:0]                   d_reg,
    output logic      [E_WIDTH-1:0]                   e_reg,
    output logic      [CTRL_COUNT-1:0][ACC_WIDTH-1:0] port_structure_ctrl,
    // execution status towards the sequencer
    output logic                                      executed,
    output logic                                      carry_keep,
    output logic                                      skip_next
);

    // decoder result for the word on the instruction bus
    decode_type                           dec;

    // qualified issue and one write strobe per destination
    logic                                 take;
    logic                                 write_d;
    logic                                 write_e;
    logic [CTRL_COUNT-1:0]                write_ctrl;

    // operand fields as each destination receives them
    logic [D_WIDTH-1:0]                   d_source;
    logic [E_WIDTH-1:0]                   e_source;
    logic [ACC_WIDTH-1:0]                 ctrl_source;

    // next values of the destination registers
    logic [D_WIDTH-1:0]                   next_d_reg;
    logic [E_WIDTH-1:0]                   next_e_reg;
    logic [CTRL_COUNT-1:0][ACC_WIDTH-1:0] next_port_structure_ctrl;

    // next values of the status outputs
    logic                                 next_executed;
    logic                                 next_carry_keep;
    logic                                 next_skip_next;

    // index of the per-register logic
    genvar                                i;

    // decoder instance; combinational, so decode and execute share a cycle
    transfer_decoder u_decoder (
        .instr (instr),
        .dec   (dec)
    );

    // an instruction of this group is executed in its issue cycle
    assign take = instr_valid && dec.hit;

    // write strobes for d and e; one decoded op means never both
    always_comb begin
        write_d = 1'b0;
        write_e = 1'b0;
        if (take) begin
            case (dec.op)
                op_d: begin
                    write_d = 1'b1;
                end
                op_e: begin
                    write_e = 1'b1;
                end
                op_ctrl: begin
                    write_d = 1'b0; // control writes have their own strobes
                end
                default: begin
                    write_d = 1'b0; // no destination
                end
            endcase
        end
    end

    // one strobe per control register, chosen by the decoded index
    generate
        for (i = 0; i < CTRL_COUNT; i++) begin : g_ctrl_strobe
            assign write_ctrl[i] = take && dec.op == op_ctrl && dec.ctrl_sel == 2'(i);
        end
    endgenerate

    // d operand: low three accumulator bits, bit 3 dropped
    assign d_source = acc[D_WIDTH-1:0];

    // e operand: register b above the accumulator
    always_comb begin
        e_source                        = E_RESET;
        e_source[E_HIGH_MSB:E_HIGH_LSB] = b_reg;
        e_source[E_LOW_MSB:E_LOW_LSB]   = acc;
    end

    // control operand: the whole accumulator
    assign ctrl_source = acc;

    // d group: hold unless the d transfer is taken
    always_comb begin
        next_d_reg = d_reg;
        if (write_d) begin
            next_d_reg = d_source;
        end
    end

    // d group: new value visible to the next instruction
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            d_reg <= D_RESET;
        end else begin
            d_reg <= next_d_reg;
        end
    end

    // e group: both nibbles load together or not at all
    always_comb begin
        next_e_reg = e_reg;
        if (write_e) begin
            next_e_reg = e_source;
        end
    end

    // e group: new value visible to the next instruction
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            e_reg <= E_RESET;
        end else begin
            e_reg <= next_e_reg;
        end
    end

    // control group: each register holds unless its own strobe fires
    generate
        for (i = 0; i < CTRL_COUNT; i++) begin : g_ctrl
            always_comb begin
                next_port_structure_ctrl[i] = port_structure_ctrl[i];
                if (write_ctrl[i]) begin
                    next_port_structure_ctrl[i] = ctrl_source;
                end
            end
        end
    endgenerate

    // control group: all four registers share one clocked process
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            port_structure_ctrl <= {CTRL_COUNT{CTRL_RESET}};
        end else begin
            port_structure_ctrl <= next_port_structure_ctrl;
        end
    end

    // status group: one-cycle pulse, carry kept, never a skip
    always_comb begin
        next_executed   = 1'b0;
        next_carry_keep = 1'b0;
        next_skip_next  = 1'b0;
        if (take) begin
            next_executed   = 1'b1;
            next_carry_keep = dec.carry_keep;
            next_skip_next  = dec.skip;
        end
    end

    // status group: registered so every output leaves a flip-flop
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            executed   <= 1'b0;
            carry_keep <= 1'b0;
            skip_next  <= 1'b0;
        end else begin
            executed   <= next_executed;
            carry_keep <= next_carry_keep;
            skip_next  <= next_skip_next;
        end
    end

endmodule

// ==== accumulator_transfer_ops_sva.sv ====
// port checker for the transfer block
`timescale 1ns/1ps
module accumulator_transfer_ops_sva
    import accumulator_transfer_pkg::*;
(
    // clock and reset
    input wire logic            clock,
    input wire logic            rst,
    // instruction issue
    input wire logic            instr_valid,
    input wire logic [9:0]      instr,
    // operands
    input wire logic [3:0]      acc,
    input wire logic [3:0]      b_reg,
    // destinations
    input wire logic [2:0]      d_reg,
    input wire logic [7:0]      e_reg,
    input wire logic [3:0][3:0] port_structure_ctrl,
    // status
    input wire logic            executed,
    input wire logic            carry_keep,
    input wire logic            skip_next
);
    logic dh, eh, ch;
    // hits of each transfer code
    assign dh = instr_valid && instr == 10'h029;
    assign eh = instr_valid && instr == 10'h01A;
    assign ch = instr_valid && instr[9:2] == 8'h8A;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_d_load: assert property (dh |=> d_reg == 3'($past(acc))) else $error("d bad");
    a_e_high: assert property (eh |=> e_reg[7:4] == $past(b_reg)) else $error("e high bad");
    a_e_low: assert property (eh |=> e_reg[3:0] == $past(acc)) else $error("e low bad");
    a_ctrl_write: assert property (ch |=> port_structure_ctrl[2'($past(instr))] == $past(acc))
        else $error("ctrl bad");
    a_ctrl_only: assert property (ch |=> $stable(d_reg) && $stable(e_reg)) else $error("ctrl side");
    a_exec_flag: assert property (dh || eh || ch |=> executed && carry_keep) else $error("exec bad");
    a_no_skip: assert property (skip_next == 1'b0) else $error("skip bad");
    a_idle_hold: assert property (!(dh || eh || ch) |=> !executed && $stable(e_reg)) else $error("idle bad");
    c_d: cover property (dh);
    c_e: cover property (eh);
    c_burst: cover property (ch ##1 ch);
endmodule
bind accumulator_transfer_ops accumulator_transfer_ops_sva accumulator_transfer_ops_sva_i (.clock(clock), .rst(rst),
    .instr_valid(instr_valid), .instr(instr), .acc(acc), .b_reg(b_reg), .d_reg(d_reg), .e_reg(e_reg),
    .port_structure_ctrl(port_structure_ctrl), .executed(executed), .carry_keep(carry_keep), .skip_next(skip_next));

// ==== accumulator_transfer_pkg.sv ====
// constants, types and codes shared by the accumulator transfer logic
package accumulator_transfer_pkg;

    // word and register widths
    localparam int INSTR_WIDTH = 10;
    localparam int ACC_WIDTH   = 4;
    localparam int D_WIDTH     = 3;
    localparam int E_WIDTH     = 8;
    localparam int CTRL_COUNT  = 4;

    // instruction codes of the transfer group
    localparam logic [9:0] CODE_MOVE_ACC_LOW3_TO_D_REG  = 10'h029;
    localparam logic [9:0] CODE_MOVE_B_AND_ACC_TO_E_REG = 10'h01A;
    localparam logic [9:0] CODE_MOVE_ACC_TO_PSC_0       = 10'h228;
    localparam logic [9:0] CODE_MOVE_ACC_TO_PSC_1       = 10'h229;
    localparam logic [9:0] CODE_MOVE_ACC_TO_PSC_2       = 10'h22A;
    localparam logic [9:0] CODE_MOVE_ACC_TO_PSC_3       = 10'h22B;

    // field positions inside register e
    localparam int E_HIGH_MSB = 7;
    localparam int E_HIGH_LSB = 4;
    localparam int E_LOW_MSB  = 3;
    localparam int E_LOW_LSB  = 0;

    // execution cost of every instruction in the group
    localparam int TRANSFER_WORDS  = 1;
    localparam int TRANSFER_CYCLES = 1;

    // values after reset
    localparam logic [2:0] D_RESET    = 3'h0;
    localparam logic [7:0] E_RESET    = 8'h00;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // decoded operation
    typedef enum logic [2:0] {
        op_none,
        op_d,
        op_e,
        op_ctrl
    } op_type;

    // decoder result carried to the execute stage
    typedef struct packed {
        logic       hit;
        op_type     op;
        logic [1:0] ctrl_sel;
        logic       carry_keep;
        logic       skip;
    } decode_type;

endpackage

// ==== tb.sv ====
// self-checking bench for the transfer block
`timescale 1ns/1ps
module tb
    import accumulator_transfer_pkg::*;
;
    logic [9:0] codes [8] = '{10'h029, 10'h01A, 10'h228, 10'h229, 10'h22A, 10'h22B, 10'h22C, 10'h028};
    logic clock = 0, rst = 1, instr_valid = 0, executed, carry_keep, skip_next;
    logic [9:0] instr = '0;
    logic [3:0] acc = '0, b_reg = '0;
    logic [2:0] d_reg;
    logic [7:0] e_reg;
    logic [3:0][3:0] port_structure_ctrl;
    logic [26:0] m = '0, q[$];
    logic [31:0] seed = 32'h28646F16;
    int err_total = 0, checks_done = 0;
    // 25 ns clock
    always #12.5 clock = ~clock;
    accumulator_transfer_ops accumulator_transfer_ops_i (.clock(clock), .rst(rst), .instr_valid(instr_valid),
        .instr(instr), .acc(acc), .b_reg(b_reg), .d_reg(d_reg), .e_reg(e_reg),
        .port_structure_ctrl(port_structure_ctrl), .executed(executed), .carry_keep(carry_keep), .skip_next(skip_next));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], ^(s & 32'h80200003)};
    endfunction
    task automatic check(input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // drive a word and note the expected state
    task automatic issue(input logic [9:0] c, input logic v);
        seed = lfsr(seed);
        {instr_valid, instr, b_reg, acc} <= {v, c, seed[7:0]};
        if (v && c == codes[0]) m[26:24] = seed[2:0];
        else if (v && c == codes[1]) m[23:16] = seed[7:0];
        else if (v && c[9:2] == 8'h8A) m[c[1:0] * 4 +: 4] = seed[3:0];
        else v = 0;
        if (v) q.push_back(m);
        @(posedge clock);
    endtask
    // compare each result with the oldest note
    always @(negedge clock) if (!rst) begin
        if (executed === 1'h1) begin
            check(q.size() != 0, 1'h1);
            check({d_reg, e_reg, port_structure_ctrl}, q.pop_front());
            check({carry_keep, skip_next}, 2'h2);
        end else begin
            check({executed, carry_keep, skip_next}, 3'h0);
        end
    end
    // reset, back to back codes, then a random mix
    initial begin
        repeat (16) @(posedge clock);
        rst <= 0;
        for (int i = 0; i < 12; i++) issue(codes[i % 6], 1);
        $display("back to back done");
        repeat (300) issue(codes[seed[2:0]], seed[4] | seed[5]);
        issue(codes[0], 0);
        check(q.size(), 0);
        $display("random mix done");
        // mid-run reset clears every destination, then one of each of the six transfer codes
        rst <= 1;
        repeat (2) @(posedge clock);
        rst <= 0;
        m = '0;
        @(negedge clock);
        check({d_reg, e_reg, port_structure_ctrl, executed, carry_keep}, 29'h0);
        @(posedge clock);
        for (int i = 0; i < 6; i++) issue(codes[i], 1);
        issue(codes[0], 0);
        check(q.size(), 0);
        $display("mid-run reset done");
        final_report();
    end
    // watchdog
    initial begin
        repeat (2000) @(posedge clock);
        err_total++;
        final_report();
    end
endmodule

// ==== transfer_decoder.sv ====
// combinational decoder for the accumulator transfer instructions
`timescale 1ns/1ps
module transfer_decoder
    import accumulator_transfer_pkg::*;
(
    // instruction in
    input  wire logic [INSTR_WIDTH-1:0] instr,
    // decoded result
    output decode_type                  dec
);

    // match the six codes; every one keeps carry and never skips
    always_comb begin
        dec            = '0;
        dec.op         = op_none;
        dec.carry_keep = 1'b1;
        dec.skip       = 1'b0;
        case (instr)
            CODE_MOVE_ACC_LOW3_TO_D_REG: begin
                dec.hit = 1'b1;
                dec.op  = op_d;
            end
            CODE_MOVE_B_AND_ACC_TO_E_REG: begin
                dec.hit = 1'b1;
                dec.op  = op_e;
            end
            CODE_MOVE_ACC_TO_PSC_0: begin
                dec.hit      = 1'b1;
                dec.op       = op_ctrl;
                dec.ctrl_sel = 2'h0;
            end
            CODE_MOVE_ACC_TO_PSC_1: begin
                dec.hit      = 1'b1;
                dec.op       = op_ctrl;
                dec.ctrl_sel = 2'h1;
            end
            CODE_MOVE_ACC_TO_PSC_2: begin
                dec.hit      = 1'b1;
                dec.op       = op_ctrl;
                dec.ctrl_sel = 2'h2;
            end
            CODE_MOVE_ACC_TO_PSC_3: begin
                dec.hit      = 1'b1;
                dec.op       = op_ctrl;
                dec.ctrl_sel = 2'h3;
            end
            default: begin
                dec.hit = 1'b0;
            end
        endcase
    end

endmodule
